// [sim/pcs_pump_model.sv]
`timescale 1ns/10ps
module pcs_pump_model
  import pcs_pkg::*;
#(
  parameter int NCH = PCS_CHANNELS
) (
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire pcs_motor_t [NCH-1:0] motor_out,
  output logic [NCH-1:0]      rev_tick_in,
  output logic [NCH-1:0]      home_found_in
);
  logic [1:0] ph_r [NCH];
  // four clocks per turn keeps the runs short
  always_ff @(posedge clock) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rst_n || !motor_out[i].run) ph_r[i] <= 2'h0;
      else ph_r[i] <= ph_r[i] + 2'h1;
      rev_tick_in[i] <= rst_n && motor_out[i].run && ph_r[i] == 2'h3;
    end
  end
  // the shaft passes home once per turn
  assign home_found_in = rev_tick_in;
endmodule : pcs_pump_model

// [sim/pcs_sequencer_monitor.sv]
`timescale 1ns/10ps
module pcs_sequencer_monitor
  import pcs_pkg::*;
#(
  parameter int NCH       = PCS_CHANNELS,
  parameter int MS_CYCLES = PCS_MS_CYCLES
) (
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 dry_contact_fire_input,
  input wire logic [NCH-1:0]       meter_hold_in,
  input wire logic [NCH-1:0]       channel_ready_out,
  input wire pcs_motor_t [NCH-1:0] motor_out
);
  logic [1:0]  mode_r;
  logic        dir_r;
  logic [4:0]  nch_r;
  logic [31:0] rate_r, prime_r, lim_r, pcnt_r;
  logic        wr, run;
  assign wr  = psel && penable && pwrite;
  assign run = motor_out[0].run;
  // shadows of the settings, channel 0 only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_r  <= 2'h0;
      dir_r   <= 1'b0;
      nch_r   <= PCS_RST_CHANNELS;
      rate_r  <= PCS_RST_RATE;
      prime_r <= PCS_RST_RATE;
      lim_r   <= PCS_RST_PRIME_LIM;
    end else if (wr) begin
      if (paddr == PCS_OFS_CTRL) mode_r <= pwdata[1:0];
      if (paddr == PCS_OFS_CTRL) dir_r <= pwdata[2];
      if (paddr == PCS_OFS_CHANNELS) nch_r <= (pwdata[4:0] > 5'(NCH)) ? 5'(NCH) : pwdata[4:0];
      if (paddr == PCS_OFS_RATE) rate_r <= pwdata;
      if (paddr == PCS_OFS_PRIME_RT) prime_r <= pwdata;
      if (paddr == PCS_OFS_PRIME_LIM) lim_r <= pwdata;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n || !(run && mode_r == 2'h0)) pcnt_r <= 32'h0;
    else pcnt_r <= pcnt_r + 32'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_meter_on;
    mode_r == 2'h2 && channel_ready_out[0] && $rose(meter_hold_in[0]);
  endsequence
  sequence s_fire;
    mode_r == 2'h1 && channel_ready_out[0] && $rose(dry_contact_fire_input);
  endsequence
  property p_ready_idle; channel_ready_out[0] |-> !run; endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready while pumping");
  property p_prime_dir; run && mode_r == 2'h0 |-> motor_out[0].reverse == dir_r; endproperty
  a_prime_dir: assert property (p_prime_dir) else $error("prime direction");
  property p_prime_rate; run && mode_r == 2'h0 |-> motor_out[0].rpm == prime_r; endproperty
  a_prime_rate: assert property (p_prime_rate) else $error("prime rate");
  property p_prime_lim; pcnt_r <= lim_r * MS_CYCLES + 4; endproperty
  a_prime_lim: assert property (p_prime_lim) else $error("prime overran limit");
  property p_meter_on; s_meter_on |-> ##[1:8] run; endproperty
  a_meter_on: assert property (p_meter_on) else $error("meter did not start");
  property p_meter_off;
    mode_r == 2'h2 && run && $fell(meter_hold_in[0]) |-> ##[1:8] !run;
  endproperty
  a_meter_off: assert property (p_meter_off) else $error("meter did not stop");
  property p_meter_rate; run && mode_r == 2'h2 |-> motor_out[0].rpm == rate_r; endproperty
  a_meter_rate: assert property (p_meter_rate) else $error("meter rate");
  property p_fire; s_fire |-> ##[1:16] run; endproperty
  a_fire: assert property (p_fire) else $error("trigger ignored");
  // ready is registered one edge behind the installed count
  property p_unused; (channel_ready_out >> $past(nch_r)) == '0; endproperty
  a_unused: assert property (p_unused) else $error("ready on absent channel");
endmodule : pcs_sequencer_monitor
bind pcs_sequencer pcs_sequencer_monitor #(.NCH(NCH), .MS_CYCLES(MS_CYCLES)) u_mon (
  .clock                  (clock),
  .rst_n                  (rst_n),
  .psel                   (psel),
  .penable                (penable),
  .pwrite                 (pwrite),
  .paddr                  (paddr),
  .pwdata                 (pwdata),
  .dry_contact_fire_input (dry_contact_fire_input),
  .meter_hold_in          (meter_hold_in),
  .channel_ready_out      (channel_ready_out),
  .motor_out              (motor_out)
);

// [sim/tb_pump_channel_mode_sequencer.sv]
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_pump_channel_mode_sequencer
  import pcs_pkg::*;
;
  localparam int NCH = PCS_CHANNELS;
  logic                 clock = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0;
  logic                 dry_contact_fire_input = 1'b0;
  logic                 system_trigger_in = 1'b0;
  logic [NCH-1:0]       channel_trigger_in = 24'h0;
  logic [NCH-1:0]       meter_hold_in = 24'h0;
  logic                 pready, pslverr;
  logic [31:0]          prdata, rd;
  logic [NCH-1:0]       rev_tick_in, home_found_in, channel_ready_out;
  pcs_motor_t [NCH-1:0] motor_out;
  int                   n_fail = 0;
  int                   checks = 0;

  always #2 clock = ~clock;

  pcs_sequencer #(
    .DEBOUNCE_CYC (4),
    .MS_CYCLES    (10)
  ) dut (
    .clock                  (clock),
    .rst_n                  (rst_n),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .pready                 (pready),
    .prdata                 (prdata),
    .pslverr                (pslverr),
    .dry_contact_fire_input (dry_contact_fire_input),
    .system_trigger_in      (system_trigger_in),
    .channel_trigger_in     (channel_trigger_in),
    .meter_hold_in          (meter_hold_in),
    .rev_tick_in            (rev_tick_in),
    .home_found_in          (home_found_in),
    .channel_ready_out      (channel_ready_out),
    .motor_out              (motor_out)
  );
  pcs_pump_model #(.NCH(NCH)) u_pump (
    .clock         (clock),
    .rst_n         (rst_n),
    .motor_out     (motor_out),
    .rev_tick_in   (rev_tick_in),
    .home_found_in (home_found_in)
  );

  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // read data stands with pready, so it is taken at that same edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 50) begin
      n_fail++;
      summarize();
    end
  endtask : xfer

  // s selects ready instead of run
  task automatic wt(input logic s, input logic v);
    int i;
    for (i = 0; i < 300; i++) begin
      if ((s ? channel_ready_out[0] : motor_out[0].run) === v) break;
      @(posedge clock);
    end
    if (i == 300) begin
      n_fail++;
      summarize();
    end
  endtask : wt

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK("ready", 1'b1, channel_ready_out[0])
    xfer(0, PCS_OFS_CHANNELS, 32'h0);
    `CHK("channels", 32'h18, rd)
    xfer(0, 12'hFFC, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("slverr", 1'b0, pslverr)
    xfer(1, PCS_OFS_CHANNELS, 32'h2);
    repeat (4) @(posedge clock);
    `CHK("absent ready", 22'h0, channel_ready_out[NCH-1:2])
    `CHK("ready ch1", 1'b1, channel_ready_out[1])
    xfer(1, PCS_OFS_CHANNELS, 32'h18);
    xfer(1, PCS_OFS_PRIME_RT, 32'h77);
    xfer(1, PCS_OFS_PRIME_LIM, 32'h2);
    xfer(1, PCS_OFS_CTRL, 32'h4);
    xfer(1, PCS_OFS_CMD, 32'h1);
    wt(0, 1);
    `CHK("prime rpm", 32'h77, motor_out[0].rpm)
    `CHK("prime dir", 1'b1, motor_out[0].reverse)
    wt(0, 0);
    xfer(1, PCS_OFS_PRIME_LIM, 32'h64);
    xfer(1, PCS_OFS_CMD, 32'h1);
    wt(0, 1);
    xfer(1, PCS_OFS_CMD, 32'h2);
    wt(0, 0);
    xfer(0, PCS_OFS_TOTAL, 32'h0);
    `CHK("prime total", 32'h0, rd)
    xfer(1, PCS_OFS_VOLUME, 32'h3);
    xfer(1, PCS_OFS_CTRL, 32'h1);
    xfer(1, PCS_OFS_CMD, 32'h1);
    wt(0, 1);
    `CHK("disp rpm", PCS_RST_RATE, motor_out[0].rpm)
    `CHK("disp dir", 1'b0, motor_out[0].reverse)
    wt(0, 0);
    xfer(0, PCS_OFS_TOTAL, 32'h0);
    `CHK("total", 32'h3, rd)
    for (int k = 0; k < 3; k++) begin
      if (k == 0) dry_contact_fire_input <= 1'b1;
      else if (k == 1) system_trigger_in <= 1'b1;
      else channel_trigger_in[0] <= 1'b1;
      wt(0, 1);
      dry_contact_fire_input <= 1'b0;
      system_trigger_in      <= 1'b0;
      channel_trigger_in     <= 24'h0;
      wt(0, 0);
      xfer(0, PCS_OFS_TOTAL, 32'h0);
      `CHK("trig total", 32'h6 + 32'(3 * k), rd)
    end
    xfer(1, PCS_OFS_DRAW_VOL, 32'h1);
    xfer(1, PCS_OFS_DRAW_RT, 32'h33);
    xfer(1, PCS_OFS_DWELL, 32'h1);
    xfer(1, PCS_OFS_CMD, 32'h1);
    wt(0, 1);
    wt(0, 0);
    wt(0, 1);
    `CHK("draw dir", 1'b1, motor_out[0].reverse)
    `CHK("draw rpm", 32'h33, motor_out[0].rpm)
    wt(0, 0);
    xfer(0, PCS_OFS_TOTAL, 32'h0);
    `CHK("draw total", 32'h10, rd)
    xfer(1, PCS_OFS_DRAW_VOL, 32'h0);
    xfer(1, PCS_OFS_VOLUME, 32'hC8);
    xfer(1, PCS_OFS_CMD, 32'h1);
    wt(0, 1);
    xfer(1, PCS_OFS_CMD, 32'h2);
    wt(0, 0);
    xfer(1, PCS_OFS_RATE, 32'h55);
    xfer(1, PCS_OFS_CTRL, 32'h2);
    meter_hold_in[0] <= 1'b1;
    wt(0, 1);
    `CHK("meter rpm", 32'h55, motor_out[0].rpm)
    meter_hold_in[0] <= 1'b0;
    wt(0, 0);
    xfer(1, PCS_OFS_CMD, 32'h1);
    wt(0, 1);
    xfer(1, PCS_OFS_CMD, 32'h2);
    wt(0, 0);
    xfer(1, PCS_OFS_CMD, 32'h10);
    xfer(1, PCS_OFS_CTRL, 32'h1);
    xfer(1, PCS_OFS_VOLUME, 32'h1);
    xfer(1, PCS_OFS_CMD, 32'h1);
    wt(0, 1);
    wt(1, 1);
    xfer(0, PCS_OFS_TOTAL, 32'h0);
    `CHK("realign total", 32'h0, rd)
    xfer(1, PCS_OFS_CMD, 32'h20);
    wt(1, 0);
    xfer(0, PCS_OFS_STATUS, 32'h0);
    `CHK("status fault", 32'h2, rd)
    xfer(1, PCS_OFS_CMD, 32'h4);
    xfer(0, PCS_OFS_STATUS, 32'h0);
    `CHK("status need ref", 32'h4, rd)
    xfer(1, PCS_OFS_CMD, 32'h1);
    repeat (8) @(posedge clock);
    `CHK("refused", 1'b0, motor_out[0].run)
    `CHK("not ready", 1'b0, channel_ready_out[0])
    xfer(1, PCS_OFS_CMD, 32'h8);
    wt(0, 1);
    wt(1, 1);
    xfer(1, PCS_OFS_CMD, 32'h1);
    wt(0, 1);
    wt(1, 1);
    xfer(0, PCS_OFS_TOTAL, 32'h0);
    `CHK("final total", 32'h1, rd)
    summarize();
  end
endmodule : tb_pump_channel_mode_sequencer

// [src/pcs_pkg.sv]
package pcs_pkg;

  localparam int          PCS_CHANNELS      = 24;
  localparam int          PCS_DATA_W        = 32;
  localparam int          PCS_CLK_MHZ       = 250;
  // register byte offsets
  localparam logic [11:0] PCS_OFS_CTRL      = 12'h000;
  localparam logic [11:0] PCS_OFS_CMD       = 12'h004;
  localparam logic [11:0] PCS_OFS_VOLUME    = 12'h008;
  localparam logic [11:0] PCS_OFS_RATE      = 12'h00C;
  localparam logic [11:0] PCS_OFS_PRIME_RT  = 12'h010;
  localparam logic [11:0] PCS_OFS_PRIME_LIM = 12'h014;
  localparam logic [11:0] PCS_OFS_DRAW_VOL  = 12'h018;
  localparam logic [11:0] PCS_OFS_DRAW_RT   = 12'h01C;
  localparam logic [11:0] PCS_OFS_DWELL     = 12'h020;
  localparam logic [11:0] PCS_OFS_STATUS    = 12'h024;
  localparam logic [11:0] PCS_OFS_TOTAL     = 12'h028;
  localparam logic [11:0] PCS_OFS_READY     = 12'h02C;
  localparam logic [11:0] PCS_OFS_CHANNELS  = 12'h030;
  // control field positions
  localparam int          PCS_CTRL_MODE_LSB = 0;
  localparam int          PCS_CTRL_DIR_BIT  = 2;
  localparam int          PCS_CTRL_SEL_LSB  = 8;
  // command bits (write one to act)
  localparam int          PCS_CMD_START     = 0;
  localparam int          PCS_CMD_STOP      = 1;
  localparam int          PCS_CMD_CLR_FAULT = 2;
  localparam int          PCS_CMD_REFERENCE = 3;
  localparam int          PCS_CMD_CLR_TOTAL = 4;
  localparam int          PCS_CMD_FAULT     = 5;
  // reset values
  localparam logic [31:0] PCS_RST_RATE      = 32'h0000_003C;
  localparam logic [31:0] PCS_RST_PRIME_LIM = 32'h0000_003C;
  localparam logic [31:0] PCS_RST_VOLUME    = 32'h0000_0001;
  localparam logic [4:0]  PCS_RST_CHANNELS  = 5'h18;
  // time units
  localparam int          PCS_MS_CYCLES     = PCS_CLK_MHZ * 1000;
  localparam int          PCS_DEBOUNCE_US   = 100;
  localparam int          PCS_DEBOUNCE_CYC  = PCS_DEBOUNCE_US * PCS_CLK_MHZ;

  typedef enum logic [1:0] {
    PCS_MODE_PRIME    = 2'h0,
    PCS_MODE_DISPENSE = 2'h1,
    PCS_MODE_METER    = 2'h2
  } pcs_mode_t;

  typedef enum logic [6:0] {
    PCS_ST_IDLE    = 7'h01,
    PCS_ST_PRIME   = 7'h02,
    PCS_ST_FORWARD = 7'h04,
    PCS_ST_DWELL   = 7'h08,
    PCS_ST_DRAW    = 7'h10,
    PCS_ST_METER   = 7'h20,
    PCS_ST_REF     = 7'h40
  } pcs_state_t;

  typedef struct packed {
    logic        run;
    logic        reverse;
    logic [31:0] rpm;
  } pcs_motor_t;

endpackage : pcs_pkg

// [src/pcs_sequencer.sv]
`timescale 1ns/10ps
// Summary of operation
// - system trigger is dry contact OR logic trigger
// - closed contact means trigger asserted
// - volume in revolutions, rate in rpm
// - prime runs continuously from start, set direction
// - prime ends on stop or time limit
// - prime rate kept separate
// - prime revolutions not totalized
// - dispense pumps set volume, stop aborts
// - dispense revolutions totalized
// - meter pumps while hardwired input asserted
// - meter also obeys panel start and stop
// - meter stop halts without homing
// - first dispense after meter realigns pump
// - meter uses dispense rate
// - up to 24 channels, extras unused
// - after fault clear, motion needs reference
// - drawback forward extra, dwell, then reverse
module pcs_sequencer
  import pcs_pkg::*;
#(
  parameter int NCH          = PCS_CHANNELS,
  parameter int DEBOUNCE_CYC = PCS_DEBOUNCE_CYC,
  parameter int MS_CYCLES    = PCS_MS_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              dry_contact_fire_input,
  input  wire logic              system_trigger_in,
  input  wire logic [NCH-1:0]    channel_trigger_in,
  input  wire logic [NCH-1:0]    meter_hold_in,
  input  wire logic [NCH-1:0]    rev_tick_in,
  input  wire logic [NCH-1:0]    home_found_in,
  output logic [NCH-1:0]         channel_ready_out,
  output pcs_motor_t [NCH-1:0]   motor_out
);

  function automatic logic [4:0] pcs_low5(input logic [31:0] v);
    return v[4:0];
  endfunction : pcs_low5

  logic [31:0] ctrl_r, volume_r, rate_r, prime_rate_r, prime_lim_r;
  logic [31:0] draw_vol_r, draw_rate_r, dwell_r;
  logic [4:0]  channels_r;
  logic        wr_acc, rd_setup;
  logic [31:0] cmd_w;
  logic [4:0]  sel;
  logic        system_trigger;

  assign wr_acc  = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign cmd_w   = (wr_acc && paddr == PCS_OFS_CMD) ? pwdata : 32'h0000_0000;
  assign sel     = pcs_low5({24'h00_0000, ctrl_r[PCS_CTRL_SEL_LSB +: 8]});
  assign system_trigger = dry_contact_fire_input | system_trigger_in;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r       <= 32'h0000_0000;
      volume_r     <= PCS_RST_VOLUME;
      rate_r       <= PCS_RST_RATE;
      prime_rate_r <= PCS_RST_RATE;
      prime_lim_r  <= PCS_RST_PRIME_LIM;
      draw_vol_r   <= 32'h0000_0000;
      draw_rate_r  <= PCS_RST_RATE;
      dwell_r      <= 32'h0000_0000;
      channels_r   <= PCS_RST_CHANNELS;
    end else if (wr_acc) begin
      case (paddr)
        PCS_OFS_CTRL:      ctrl_r       <= pwdata;
        PCS_OFS_VOLUME:    volume_r     <= pwdata;
        PCS_OFS_RATE:      rate_r       <= pwdata;
        PCS_OFS_PRIME_RT:  prime_rate_r <= pwdata;
        PCS_OFS_PRIME_LIM: prime_lim_r  <= pwdata;
        PCS_OFS_DRAW_VOL:  draw_vol_r   <= pwdata;
        PCS_OFS_DRAW_RT:   draw_rate_r  <= pwdata;
        PCS_OFS_DWELL:     dwell_r      <= pwdata;
        PCS_OFS_CHANNELS:  channels_r   <= (pcs_low5(pwdata) > 5'(NCH)) ? 5'(NCH)
                                           : pcs_low5(pwdata);
        default: ;
      endcase
    end
  end

  logic [NCH-1:0]  busy, faulted, need_ref;
  logic [31:0]     total [NCH];
  logic [31:0]     rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      PCS_OFS_CTRL:      rd_mux = ctrl_r;
      PCS_OFS_VOLUME:    rd_mux = volume_r;
      PCS_OFS_RATE:      rd_mux = rate_r;
      PCS_OFS_PRIME_RT:  rd_mux = prime_rate_r;
      PCS_OFS_PRIME_LIM: rd_mux = prime_lim_r;
      PCS_OFS_DRAW_VOL:  rd_mux = draw_vol_r;
      PCS_OFS_DRAW_RT:   rd_mux = draw_rate_r;
      PCS_OFS_DWELL:     rd_mux = dwell_r;
      PCS_OFS_STATUS:    rd_mux = {29'h0, need_ref[sel], faulted[sel], busy[sel]};
      PCS_OFS_TOTAL:     rd_mux = (sel < 5'(NCH)) ? total[sel] : 32'h0000_0000;
      PCS_OFS_READY:     rd_mux = 32'(channel_ready_out);
      PCS_OFS_CHANNELS:  rd_mux = {27'h0, channels_r};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // latched in setup so read data already stands when pready is sampled
  // no error response: unmapped reads give zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= rd_setup ? rd_mux : prdata;
      pslverr <= 1'b0;
    end
  end

  pcs_mode_t mode;
  assign mode = pcs_mode_t'(ctrl_r[PCS_CTRL_MODE_LSB +: 2]);

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      pcs_state_t  st_r;
      logic [31:0] revs_r, ms_r, tick_r;
      logic [2:0]  trig_sync_r;
      logic        trig_db_r, trig_db_prev_r, meter_prev_r, was_meter_r;
      logic [$clog2(DEBOUNCE_CYC+1)-1:0] db_cnt_r;
      logic        present, hit, start_cmd, stop_cmd, fire, meter_rise, meter_fall;

      assign present    = 5'(g) < channels_r;
      assign hit        = present && (sel == 5'(g));
      assign start_cmd  = hit && cmd_w[PCS_CMD_START];
      assign stop_cmd   = hit && cmd_w[PCS_CMD_STOP];
      assign fire       = present && trig_db_r && !trig_db_prev_r;
      assign meter_rise = present && meter_hold_in[g] && !meter_prev_r;
      assign meter_fall = meter_prev_r && !meter_hold_in[g];

      // debounce: level must hold steady before it is believed
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          trig_sync_r    <= 3'h0;
          db_cnt_r       <= '0;
          trig_db_r      <= 1'b0;
          trig_db_prev_r <= 1'b0;
          meter_prev_r   <= 1'b0;
        end else begin
          trig_sync_r    <= {trig_sync_r[1:0], channel_trigger_in[g] | system_trigger};
          trig_db_prev_r <= trig_db_r;
          meter_prev_r   <= meter_hold_in[g];
          if (trig_sync_r[2] == trig_db_r) begin
            db_cnt_r <= '0;
          end else if (db_cnt_r == ($bits(db_cnt_r))'(DEBOUNCE_CYC - 1)) begin
            db_cnt_r  <= '0;
            trig_db_r <= trig_sync_r[2];
          end else begin
            db_cnt_r <= db_cnt_r + 1'b1;
          end
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          faulted[g]  <= 1'b0;
          need_ref[g] <= 1'b0;
        end else begin
          // set after clear so a fresh fault clear wins over a home hit
          if (st_r == PCS_ST_REF && home_found_in[g]) begin
            need_ref[g] <= 1'b0;
          end
          if (hit && cmd_w[PCS_CMD_FAULT]) begin
            faulted[g] <= 1'b1;
          end else if (hit && cmd_w[PCS_CMD_CLR_FAULT] && faulted[g]) begin
            faulted[g]  <= 1'b0;
            need_ref[g] <= 1'b1;
          end
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          st_r        <= PCS_ST_IDLE;
          revs_r      <= 32'h0000_0000;
          ms_r        <= 32'h0000_0000;
          tick_r      <= 32'h0000_0000;
          was_meter_r <= 1'b0;
          total[g]    <= 32'h0000_0000;
        end else begin
          if (hit && cmd_w[PCS_CMD_CLR_TOTAL]) begin
            total[g] <= 32'h0000_0000;
          end else if (rev_tick_in[g] && st_r == PCS_ST_FORWARD) begin
            total[g] <= total[g] + 32'h0000_0001;
          end
          if (mode == PCS_MODE_METER) begin
            was_meter_r <= 1'b1;
          end
          case (st_r)
            PCS_ST_IDLE: begin
              revs_r <= 32'h0000_0000;
              ms_r   <= 32'h0000_0000;
              tick_r <= 32'h0000_0000;
              if (faulted[g]) begin
                st_r <= PCS_ST_IDLE;
              end else if (hit && cmd_w[PCS_CMD_REFERENCE]) begin
                st_r <= PCS_ST_REF;
              end else if (need_ref[g]) begin
                st_r <= PCS_ST_IDLE;
              end else if (mode == PCS_MODE_PRIME && start_cmd) begin
                st_r <= PCS_ST_PRIME;
              end else if (mode == PCS_MODE_DISPENSE && (start_cmd || fire)) begin
                st_r <= was_meter_r ? PCS_ST_REF : PCS_ST_FORWARD;
                was_meter_r <= 1'b0;
              end else if (mode == PCS_MODE_METER && (start_cmd || meter_rise)) begin
                st_r <= PCS_ST_METER;
              end
            end
            PCS_ST_PRIME: begin
              if (tick_r == 32'(MS_CYCLES - 1)) begin
                tick_r <= 32'h0000_0000;
                ms_r   <= ms_r + 32'h0000_0001;
              end else begin
                tick_r <= tick_r + 32'h0000_0001;
              end
              if (stop_cmd || faulted[g] || ms_r >= prime_lim_r) begin
                st_r <= PCS_ST_IDLE;
              end
            end
            PCS_ST_FORWARD: begin
              if (rev_tick_in[g]) begin
                revs_r <= revs_r + 32'h0000_0001;
              end
              if (stop_cmd || faulted[g]) begin
                st_r <= PCS_ST_IDLE;
              end else if (rev_tick_in[g] &&
                           revs_r + 32'h0000_0001 >= volume_r + draw_vol_r) begin
                revs_r <= 32'h0000_0000;
                st_r   <= (draw_vol_r != 32'h0000_0000) ? PCS_ST_DWELL : PCS_ST_IDLE;
              end
            end
            PCS_ST_DWELL: begin
              if (tick_r == 32'(MS_CYCLES - 1)) begin
                tick_r <= 32'h0000_0000;
                ms_r   <= ms_r + 32'h0000_0001;
              end else begin
                tick_r <= tick_r + 32'h0000_0001;
              end
              if (stop_cmd || faulted[g]) begin
                st_r <= PCS_ST_IDLE;
              end else if (ms_r >= dwell_r) begin
                st_r <= PCS_ST_DRAW;
              end
            end
            PCS_ST_DRAW: begin
              if (rev_tick_in[g]) begin
                revs_r <= revs_r + 32'h0000_0001;
              end
              if (stop_cmd || faulted[g] ||
                  (rev_tick_in[g] && revs_r + 32'h0000_0001 >= draw_vol_r)) begin
                st_r <= PCS_ST_IDLE;
              end
            end
            PCS_ST_METER: begin
              // immediate halt, no homing move
              if (stop_cmd || meter_fall || faulted[g]) begin
                st_r <= PCS_ST_IDLE;
              end
            end
            PCS_ST_REF: begin
              if (home_found_in[g] || faulted[g]) begin
                st_r <= PCS_ST_IDLE;
              end
            end
            default: st_r <= PCS_ST_IDLE;
          endcase
        end
      end

      assign busy[g] = st_r != PCS_ST_IDLE;

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          motor_out[g]         <= '0;
          channel_ready_out[g] <= 1'b0;
        end else begin
          // pump stands still during the dwell pause
          motor_out[g].run     <= st_r != PCS_ST_IDLE && st_r != PCS_ST_DWELL
                                  && !faulted[g];
          motor_out[g].reverse <= (st_r == PCS_ST_DRAW) ^ ctrl_r[PCS_CTRL_DIR_BIT];
          motor_out[g].rpm     <= (st_r == PCS_ST_PRIME) ? prime_rate_r
                                : (st_r == PCS_ST_DRAW)  ? draw_rate_r
                                : rate_r;
          channel_ready_out[g] <= present && st_r == PCS_ST_IDLE && !faulted[g]
                                  && !need_ref[g] && !fire;
        end
      end
    end
  endgenerate

endmodule : pcs_sequencer
